/* File: tb.sv */
`timescale 1ns/100ps
module tb;
   import usb_ep_ctrl_pkg::*;
   localparam int E_ACK = 5, E_OUT = 6, E_SETUP = 7, E_STALL = 8, E_OK = 9;
   localparam int E_BAD = 10, E_FREE = 11, E_TOG = 12, E_BRST = 13;
   localparam logic [7:0] SEL = IDX_ENDPOINT_INDEX_SELECT, CSR = IDX_ENDPOINT_CONTROL_STATUS;
   localparam logic [7:0] CNT = IDX_ENDPOINT_RX_BYTE_COUNT, FCT = IDX_ENDPOINT_FUNCTION_CONTROL;
   localparam logic [7:0] PFL = IDX_PROTOCOL_IRQ_FLAGS, PMK = IDX_PROTOCOL_IRQ_MASK;
   localparam logic [7:0] EFL = IDX_ENDPOINT_IRQ_FLAGS, EMK = IDX_ENDPOINT_IRQ_MASK;
   localparam logic [7:0] RST = IDX_ENDPOINT_RESET_CONTROL;
   typedef struct {string name; logic [31:0] val;} note_t;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, module_enable = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, protocol_irq, endpoint_irq, rd_dph = 1'b0;
   logic [13:0] pulse;
   logic [2:0] ev_endpoint;
   logic [7:0] ev_byte_count, ep_enable, ep_force_stall, ep_tx_bank_busy, ep_direction;
   logic [7:0] ep_data_toggle, ep_pointer_reset, cnt, en, dir;
   logic [15:0] ep_type;
   logic bus_reset, ev_suspend, ev_resume, ev_remote_wake, ev_frame_start, ev_bus_reset_end;
   logic ev_in_ack, ev_out_data, ev_setup, ev_stall_sent, ev_iso_crc_good, ev_iso_crc_bad;
   logic ev_tx_bank_free, ev_toggle_flip;
   logic [7:0] fc [8];
   logic [7:0] ridx [10] = '{SEL, CSR, CNT, FCT, PFL, PMK, EFL, EMK, RST, 8'h00};
   logic [7:0] rrst [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
   note_t notes [$];
   int fails = 0, checks = 0, seed = 69460;
   assign {bus_reset, ev_toggle_flip, ev_tx_bank_free, ev_iso_crc_bad, ev_iso_crc_good} = pulse[13:9];
   assign {ev_stall_sent, ev_setup, ev_out_data, ev_in_ack, ev_bus_reset_end} = pulse[8:4];
   assign {ev_frame_start, ev_remote_wake, ev_resume, ev_suspend} = pulse[3:0];
   usb_device_endpoint_control u_usb_device_endpoint_control (.*, .hsize(3'h2), .hready(hreadyout));
   usb_link_model u_usb_link_model (.*);
   initial begin
      forever #2 hclk = ~hclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string n);
      notes.push_back('{n, {24'h0, e}});
      bus(1'b0, idx, 8'h00);
   endtask : rd
   task automatic settle;
      repeat (2) @(negedge hclk);
   endtask : settle
   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // read results compared in order of issue
   always @(posedge hclk) begin
      if (rd_dph && hreadyout) begin
         chk(notes[0].name, notes[0].val, hrdata);
         void'(notes.pop_front());
      end
      if (hreadyout) begin
         rd_dph <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
      end
   end
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      module_enable <= 1'b1;
      @(posedge hclk);
      foreach (ridx[i]) rd(ridx[i], rrst[i], "reset value");
      for (int k = 0; k < 5; k++) begin
         u_usb_link_model.fire(k, 3'h0, 8'h00);
         rd(PFL, 8'h01 << k, "protocol flag");
         settle();
         chk("protocol_irq", k == PF_RESUME || k == PF_BUS_RESET_END, protocol_irq);
         @(posedge hclk);
         wr(PFL, 8'h00);
      end
      wr(PFL, 8'h04);
      rd(PFL, 8'h04, "software flag");
      wr(PMK, 8'hff);
      rd(PMK, 8'h0f, "protocol mask");
      settle();
      chk("protocol_irq", 1, {hresp, protocol_irq});
      @(posedge hclk);
      wr(PMK, 8'h00);
      wr(PFL, 8'h00);
      for (int e = 0; e < 8; e++) begin
         fc[e] = (8'($random(seed)) & 8'h84) | 8'(e % 4);
         en[e] = fc[e][7];
         dir[e] = fc[e][2];
         wr(SEL, 8'(e));
         wr(FCT, fc[e] | 8'h78);
      end
      for (int e = 0; e < 8; e++) begin
         wr(SEL, 8'(e));
         rd(FCT, fc[e], "function control");
      end
      settle();
      chk("endpoint outputs", {16'he4e4, en, dir}, {ep_type, ep_enable, ep_direction});
      @(posedge hclk);
      wr(EMK, 8'hff);
      rd(EMK, 8'hff, "endpoint mask");
      wr(SEL, 8'h00);
      for (int k = 0; k < 4; k++) begin
         u_usb_link_model.fire(E_ACK + k, 3'h0, 8'h00);
         rd(CSR, 8'h01 << k, "control status");
         rd(EFL, 8'h01, "endpoint flags");
         chk("endpoint_irq", 1, endpoint_irq);
         wr(CSR, 8'h00);
         rd(EFL, 8'h00, "endpoint flags cleared");
      end
      cnt = 8'($random(seed));
      u_usb_link_model.fire(E_OUT, 3'h3, cnt);
      wr(SEL, 8'h03);
      rd(CNT, cnt, "byte count");
      rd(CSR, 8'h02, "data received");
      rd(EFL, dir[3] ? 8'h00 : 8'h08, "interrupt out flag");
      wr(CSR, 8'h00);
      wr(SEL, 8'h01);
      u_usb_link_model.fire(E_BAD, 3'h1, 8'h00);
      rd(CSR, 8'h40, "iso error");
      u_usb_link_model.fire(E_STALL, 3'h1, 8'h00);
      rd(CSR, 8'h48, "iso stall");
      rd(EFL, 8'h00, "iso flags");
      u_usb_link_model.fire(E_OK, 3'h1, 8'h00);
      rd(CSR, 8'h08, "iso good crc");
      wr(CSR, 8'h00);
      wr(EFL, 8'hff);
      u_usb_link_model.fire(E_SETUP, 3'h1, 8'h00);
      rd(CSR, 8'h00, "setup outside control");
      rd(EFL, 8'h00, "read-only flags");
      wr(SEL, 8'h00);
      wr(CSR, 8'h30);
      settle();
      chk("stall and busy", 17'h00101, {endpoint_irq, ep_force_stall, ep_tx_bank_busy});
      @(posedge hclk);
      u_usb_link_model.fire(E_FREE, 3'h0, 8'h00);
      rd(CSR, 8'h20, "bank freed");
      wr(CSR, 8'h00);
      u_usb_link_model.fire(E_TOG, 3'h5, 8'h00);
      settle();
      chk("toggle", 8'h20, ep_data_toggle);
      @(posedge hclk);
      wr(RST, 8'h00);
      wr(RST, 8'h20);
      // the bit still reads one right after the write; the pointer pulse follows a cycle later
      fork
         rd(RST, 8'h20, "endpoint reset pending");
         begin
            repeat (2) @(negedge hclk);
            chk("ep_pointer_reset", 8'h20, ep_pointer_reset);
         end
      join
      rd(RST, 8'h00, "endpoint reset done");
      settle();
      chk("toggle reset", 8'h00, ep_data_toggle);
      @(posedge hclk);
      u_usb_link_model.fire(E_BRST, 3'h0, 8'h00);
      settle();
      chk("ep_enable", 8'h01, ep_enable);
      @(posedge hclk);
      rd(FCT, 8'h80, "bus reset control");
      wr(PMK, 8'h0f);
      module_enable <= 1'b0;
      @(posedge hclk);
      module_enable <= 1'b1;
      @(posedge hclk);
      rd(PMK, 8'h02, "disabled mask");
      @(posedge hclk);
      end_of_test();
   end
endmodule : tb

/* File: usb_device_endpoint_control.sv */
`timescale 1ns/100ps
// Functional notes
// RQ1 - suspend seen on the bus sets the suspend flag; stays until software writes zero
// RQ2 - software writing one to any protocol flag sets it like a hardware event
// RQ3 - protocol mask: frame start b3, remote wake b2, resume b1, suspend b0; reset 0x02
// RQ4 - endpoint flag set on a condition, cleared once its sources are all cleared
// RQ5 - conditions: ack, received data, setup, stall sent, each qualified by mode
// RQ6 - one endpoint mask bit per endpoint, one enables, resets to zero
// RQ7 - 3-bit endpoint index steers every per-endpoint register access
// RQ8 - software selects the endpoint index before touching per-endpoint registers
// RQ9 - iso error bit follows the CRC of iso packets, never an interrupt source
// RQ10 - force stall answers IN and OUT tokens with STALL, not an interrupt source
// RQ11 - software sets tx bank busy when filled; hardware clears it once bank is free
// RQ12 - stall sent bit set after a STALL is sent; interrupt source, software clears
// RQ13 - control endpoint sets setup bit on valid SETUP; interrupt source, software clears
// RQ14 - received data bit set when buffer filled by host; interrupt source
// RQ15 - ack bit set when host acks sent data; interrupt source, software clears
// RQ16 - 8-bit received byte count per endpoint, valid once data-received is set
// RQ17 - endpoint enable bit; while zero the endpoint ignores host transactions
// RQ18 - bus reset sets the enable bit of endpoint 0
// RQ19 - direction bit: one IN, zero OUT; ignored for control endpoints
// RQ20 - type field: 0 control, 1 isochronous, 2 bulk, 3 interrupt
// RQ21 - endpoint reset bit resets pointers and data toggle, then hardware clears it
// RQ22 - software clears, sets, then polls the reset bit until hardware clears it
// RQ23 - bus reset end flag reaches the protocol interrupt with no mask
// RQ24 - frame start identifier on the bus sets the frame start flag; software clears
// RQ25 - interrupt requests: any flag with its enable, or unmasked bus reset end
module usb_device_endpoint_control
   import usb_ep_ctrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // link engine events, same clock
   input wire logic module_enable,
   input wire logic bus_reset,
   input wire logic ev_suspend,
   input wire logic ev_resume,
   input wire logic ev_remote_wake,
   input wire logic ev_frame_start,
   input wire logic ev_bus_reset_end,
   input wire logic [2:0] ev_endpoint,
   input wire logic ev_in_ack,
   input wire logic ev_out_data,
   input wire logic [7:0] ev_byte_count,
   input wire logic ev_setup,
   input wire logic ev_stall_sent,
   input wire logic ev_iso_crc_good,
   input wire logic ev_iso_crc_bad,
   input wire logic ev_tx_bank_free,
   input wire logic ev_toggle_flip,
   // endpoint controls to the link engine
   output logic [7:0] ep_enable,
   output logic [7:0] ep_force_stall,
   output logic [7:0] ep_tx_bank_busy,
   output logic [7:0] ep_direction,
   output logic [15:0] ep_type,
   output logic [7:0] ep_data_toggle,
   output logic [7:0] ep_pointer_reset,
   // interrupt requests
   output logic protocol_irq,
   output logic endpoint_irq
);

   ep_ctrl_state_t st_reg;
   ep_ctrl_state_t st_next;

   logic addr_ok;
   logic rd_req;
   logic wr_req;
   logic [7:0] req_index;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic [2:0] sel;
   logic [7:0] ev_hit;
   logic [7:0] ep_sources;

   assign sel = st_reg.endpoint_index; // [RQ7]
   assign req_index = haddr[9:2];
   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign rd_req = addr_ok && !hwrite;
   assign wr_req = addr_ok && hwrite;
   assign wbyte = hwdata[7:0];
   // a read right behind a write waits one cycle so it sees the new value
   assign hreadyout = !(st_reg.wr_pending && hsel && (htrans == HTRANS_NONSEQ) && !hwrite);
   assign hresp = 1'b0;
   assign hrdata = st_reg.rdata;

   // read value of the register at the requested index
   always_comb begin
      rbyte = BYTE_RESET;
      if (req_index == IDX_ENDPOINT_INDEX_SELECT) begin
         rbyte = {5'h00, st_reg.endpoint_index};
      end else if (req_index == IDX_ENDPOINT_CONTROL_STATUS) begin
         rbyte[CS_IN_ACK] = st_reg.in_ack_received[sel];
         rbyte[CS_OUT_DATA] = st_reg.out_data_received[sel];
         rbyte[CS_SETUP] = st_reg.setup_received[sel];
         rbyte[CS_STALL_SENT] = st_reg.stall_sent[sel];
         rbyte[CS_TX_BUSY] = st_reg.tx_bank_busy[sel];
         rbyte[CS_FORCE_STALL] = st_reg.force_stall[sel];
         rbyte[CS_ISO_ERR] = st_reg.iso_crc_error[sel];
      end else if (req_index == IDX_ENDPOINT_RX_BYTE_COUNT) begin
         rbyte = st_reg.rx_byte_count[sel];
      end else if (req_index == IDX_ENDPOINT_FUNCTION_CONTROL) begin
         rbyte[FC_ENABLE] = st_reg.endpoint_enable[sel];
         rbyte[FC_DIRECTION] = st_reg.endpoint_direction[sel];
         rbyte[FC_TYPE_HI:FC_TYPE_LO] = st_reg.endpoint_type[sel];
      end else if (req_index == IDX_PROTOCOL_IRQ_FLAGS) begin
         rbyte = {3'h0, st_reg.protocol_irq_flags};
      end else if (req_index == IDX_PROTOCOL_IRQ_MASK) begin
         rbyte = {4'h0, st_reg.protocol_irq_mask};
      end else if (req_index == IDX_ENDPOINT_IRQ_FLAGS) begin
         rbyte = st_reg.endpoint_irq_flags;
      end else if (req_index == IDX_ENDPOINT_IRQ_MASK) begin
         rbyte = st_reg.endpoint_irq_mask;
      end else if (req_index == IDX_ENDPOINT_RESET_CONTROL) begin
         rbyte = st_reg.endpoint_reset_bit;
      end
   end

   always_comb begin
      st_next = st_reg;
      ev_hit = 8'h00;
      ep_sources = 8'h00;

      // bus slave address phase
      st_next.wr_pending = wr_req && hreadyout;
      st_next.wr_index = req_index;
      if (rd_req && hreadyout) begin
         st_next.rdata = {24'h000000, rbyte};
      end

      // hardware clears requested endpoint resets one cycle after they land
      st_next.ptr_reset = st_reg.endpoint_reset_bit;
      st_next.endpoint_reset_bit = 8'h00; // [RQ21]

      // software writes in the data phase
      if (st_reg.wr_pending) begin
         if (st_reg.wr_index == IDX_ENDPOINT_INDEX_SELECT) begin
            st_next.endpoint_index = wbyte[2:0]; // [RQ7]
         end else if (st_reg.wr_index == IDX_ENDPOINT_CONTROL_STATUS) begin
            st_next.in_ack_received[sel] = wbyte[CS_IN_ACK];
            st_next.out_data_received[sel] = wbyte[CS_OUT_DATA];
            st_next.setup_received[sel] = wbyte[CS_SETUP];
            st_next.stall_sent[sel] = wbyte[CS_STALL_SENT];
            st_next.tx_bank_busy[sel] = wbyte[CS_TX_BUSY]; // [RQ11]
            st_next.force_stall[sel] = wbyte[CS_FORCE_STALL]; // [RQ10]
         end else if (st_reg.wr_index == IDX_ENDPOINT_RX_BYTE_COUNT) begin
            st_next.rx_byte_count[sel] = wbyte;
         end else if (st_reg.wr_index == IDX_ENDPOINT_FUNCTION_CONTROL) begin
            st_next.endpoint_enable[sel] = wbyte[FC_ENABLE]; // [RQ17]
            st_next.endpoint_direction[sel] = wbyte[FC_DIRECTION]; // [RQ19]
            st_next.endpoint_type[sel] = wbyte[FC_TYPE_HI:FC_TYPE_LO]; // [RQ20]
         end else if (st_reg.wr_index == IDX_PROTOCOL_IRQ_FLAGS) begin
            st_next.protocol_irq_flags = wbyte[4:0]; // [RQ2]
         end else if (st_reg.wr_index == IDX_PROTOCOL_IRQ_MASK) begin
            st_next.protocol_irq_mask = wbyte[3:0]; // [RQ3]
         end else if (st_reg.wr_index == IDX_ENDPOINT_IRQ_MASK) begin
            st_next.endpoint_irq_mask = wbyte; // [RQ6]
         end else if (st_reg.wr_index == IDX_ENDPOINT_RESET_CONTROL) begin
            st_next.endpoint_reset_bit = wbyte; // [RQ21]
         end
      end

      // hardware protocol events win over a software clear in the same cycle
      if (ev_suspend) begin
         st_next.protocol_irq_flags[PF_SUSPEND] = 1'b1; // [RQ1]
      end
      if (ev_resume) begin
         st_next.protocol_irq_flags[PF_RESUME] = 1'b1;
      end
      if (ev_remote_wake) begin
         st_next.protocol_irq_flags[PF_REMOTE_WAKE] = 1'b1;
      end
      if (ev_frame_start) begin
         st_next.protocol_irq_flags[PF_FRAME_START] = 1'b1; // [RQ24]
      end
      if (ev_bus_reset_end) begin
         st_next.protocol_irq_flags[PF_BUS_RESET_END] = 1'b1;
      end

      // endpoint events from the link engine
      ev_hit[ev_endpoint] = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (ev_hit[i]) begin
            if (ev_in_ack) begin
               st_next.in_ack_received[i] = 1'b1; // [RQ15]
            end
            if (ev_out_data) begin
               st_next.out_data_received[i] = 1'b1; // [RQ14]
               st_next.rx_byte_count[i] = ev_byte_count; // [RQ16]
            end
            if (ev_setup && (st_reg.endpoint_type[i] == TYPE_CONTROL)) begin
               st_next.setup_received[i] = 1'b1; // [RQ13]
            end
            if (ev_stall_sent) begin
               st_next.stall_sent[i] = 1'b1; // [RQ12]
            end
            if (st_reg.endpoint_type[i] == TYPE_ISO) begin
               if (ev_iso_crc_bad) begin
                  st_next.iso_crc_error[i] = 1'b1; // [RQ9]
               end else if (ev_iso_crc_good) begin
                  st_next.iso_crc_error[i] = 1'b0; // [RQ9]
               end
            end
            if (ev_tx_bank_free) begin
               st_next.tx_bank_busy[i] = 1'b0; // [RQ11]
            end
            if (ev_toggle_flip) begin
               st_next.data_toggle[i] = !st_reg.data_toggle[i];
            end
         end
         // endpoint reset forces the toggle back to zero
         if (st_reg.endpoint_reset_bit[i]) begin
            st_next.data_toggle[i] = 1'b0; // [RQ21]
         end
      end

      // endpoint flag: any mode-qualified source, iso error and stall control excluded
      for (int i = 0; i < 8; i++) begin
         ep_sources[i] =
            (st_next.in_ack_received[i] && (st_next.endpoint_type[i] == TYPE_CONTROL ||
               (st_next.endpoint_direction[i] && st_next.endpoint_type[i] != TYPE_ISO))) ||
            (st_next.out_data_received[i] && (st_next.endpoint_type[i] == TYPE_CONTROL ||
               !st_next.endpoint_direction[i])) ||
            (st_next.setup_received[i] && (st_next.endpoint_type[i] == TYPE_CONTROL)) ||
            (st_next.stall_sent[i] && (st_next.endpoint_type[i] != TYPE_ISO)); // [RQ5]
      end
      st_next.endpoint_irq_flags = ep_sources; // [RQ4]

      // bus reset clears endpoint state and enables endpoint 0
      if (bus_reset) begin
         st_next.in_ack_received = 8'h00;
         st_next.out_data_received = 8'h00;
         st_next.setup_received = 8'h00;
         st_next.stall_sent = 8'h00;
         st_next.tx_bank_busy = 8'h00;
         st_next.force_stall = 8'h00;
         st_next.iso_crc_error = 8'h00;
         st_next.endpoint_direction = 8'h00;
         st_next.data_toggle = 8'h00;
         st_next.endpoint_type = '0;
         st_next.rx_byte_count = '0;
         st_next.endpoint_irq_flags = 8'h00;
         st_next.endpoint_enable = 8'h01; // [RQ18]
      end

      // interrupt requests
      st_next.protocol_irq = |(st_next.protocol_irq_flags[3:0] & st_next.protocol_irq_mask) ||
         st_next.protocol_irq_flags[PF_BUS_RESET_END]; // [RQ23] [RQ25]
      st_next.endpoint_irq =
         |(st_next.endpoint_irq_flags & st_next.endpoint_irq_mask); // [RQ6] [RQ25]

      // module disable holds everything but the bus slave at reset values
      if (!module_enable) begin
         st_next = '0;
         st_next.protocol_irq_mask = PROTOCOL_IRQ_MASK_RESET;
         st_next.wr_pending = wr_req && hreadyout;
         st_next.wr_index = req_index;
         st_next.rdata = st_reg.rdata;
         if (rd_req && hreadyout) begin
            st_next.rdata = {24'h000000, rbyte};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
         st_reg.protocol_irq_mask <= PROTOCOL_IRQ_MASK_RESET; // [RQ3]
      end else begin
         st_reg <= st_next;
      end
   end

   // endpoint controls for token handling in the link engine
   assign ep_enable = st_reg.endpoint_enable; // [RQ17]
   assign ep_force_stall = st_reg.force_stall; // [RQ10]
   assign ep_tx_bank_busy = st_reg.tx_bank_busy;
   assign ep_direction = st_reg.endpoint_direction;
   assign ep_type = st_reg.endpoint_type;
   assign ep_data_toggle = st_reg.data_toggle;
   assign ep_pointer_reset = st_reg.ptr_reset; // [RQ21]
   assign protocol_irq = st_reg.protocol_irq;
   assign endpoint_irq = st_reg.endpoint_irq;

endmodule : usb_device_endpoint_control

/* File: usb_ep_ctrl_pkg.sv */
package usb_ep_ctrl_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_ENDPOINT_INDEX_SELECT = 8'hca;
   localparam logic [7:0] IDX_ENDPOINT_CONTROL_STATUS = 8'hcb;
   localparam logic [7:0] IDX_ENDPOINT_RX_BYTE_COUNT = 8'hcc;
   localparam logic [7:0] IDX_ENDPOINT_FUNCTION_CONTROL = 8'hcd;
   localparam logic [7:0] IDX_PROTOCOL_IRQ_FLAGS = 8'he1;
   localparam logic [7:0] IDX_PROTOCOL_IRQ_MASK = 8'he2;
   localparam logic [7:0] IDX_ENDPOINT_IRQ_FLAGS = 8'he3;
   localparam logic [7:0] IDX_ENDPOINT_IRQ_MASK = 8'he4;
   localparam logic [7:0] IDX_ENDPOINT_RESET_CONTROL = 8'he5;

   // reset values
   localparam logic [3:0] PROTOCOL_IRQ_MASK_RESET = 4'h2;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // protocol flag and mask bit positions
   localparam int PF_SUSPEND = 0;
   localparam int PF_RESUME = 1;
   localparam int PF_REMOTE_WAKE = 2;
   localparam int PF_FRAME_START = 3;
   localparam int PF_BUS_RESET_END = 4;

   // endpoint control/status bit positions
   localparam int CS_IN_ACK = 0;
   localparam int CS_OUT_DATA = 1;
   localparam int CS_SETUP = 2;
   localparam int CS_STALL_SENT = 3;
   localparam int CS_TX_BUSY = 4;
   localparam int CS_FORCE_STALL = 5;
   localparam int CS_ISO_ERR = 6;

   // function control bit positions
   localparam int FC_ENABLE = 7;
   localparam int FC_DIRECTION = 2;
   localparam int FC_TYPE_HI = 1;
   localparam int FC_TYPE_LO = 0;

   // endpoint transfer types
   localparam logic [1:0] TYPE_CONTROL = 2'h0;
   localparam logic [1:0] TYPE_ISO = 2'h1;
   localparam logic [1:0] TYPE_BULK = 2'h2;
   localparam logic [1:0] TYPE_INTERRUPT = 2'h3;

   // ahb transfer type
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      // bus slave
      logic wr_pending;
      logic [7:0] wr_index;
      logic [31:0] rdata;
      // global registers
      logic [2:0] endpoint_index;
      logic [3:0] protocol_irq_mask;
      logic [4:0] protocol_irq_flags;
      logic [7:0] endpoint_irq_mask;
      logic [7:0] endpoint_irq_flags;
      logic [7:0] endpoint_reset_bit;
      logic [7:0] ptr_reset;
      // per-endpoint state, one bit per endpoint, except two type bits and a byte count per endpoint
      logic [7:0] in_ack_received;
      logic [7:0] out_data_received;
      logic [7:0] setup_received;
      logic [7:0] stall_sent;
      logic [7:0] tx_bank_busy;
      logic [7:0] force_stall;
      logic [7:0] iso_crc_error;
      logic [7:0] endpoint_enable;
      logic [7:0] endpoint_direction;
      logic [7:0] data_toggle;
      logic [7:0][1:0] endpoint_type;
      logic [7:0][7:0] rx_byte_count;
      // interrupt requests
      logic protocol_irq;
      logic endpoint_irq;
   } ep_ctrl_state_t;

endpackage : usb_ep_ctrl_pkg

/* File: usb_ep_ctrl_properties.sv */
`timescale 1ns/100ps
module usb_ep_ctrl_properties
   import usb_ep_ctrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic module_enable,
   input wire logic bus_reset,
   input wire logic ev_bus_reset_end,
   input wire logic [2:0] ev_endpoint,
   input wire logic ev_in_ack,
   input wire logic ev_out_data,
   input wire logic ev_setup,
   input wire logic ev_stall_sent,
   input wire logic ev_tx_bank_free,
   input wire logic ev_toggle_flip,
   input wire logic [7:0] ep_enable,
   input wire logic [7:0] ep_force_stall,
   input wire logic [7:0] ep_tx_bank_busy,
   input wire logic [7:0] ep_data_toggle,
   input wire logic [7:0] ep_pointer_reset,
   input wire logic protocol_irq,
   input wire logic endpoint_irq
);
   logic wr_dph;
   // marks the data phase of a bus write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dph <= 1'b0;
      end else if (hready) begin
         wr_dph <= hsel && htrans == HTRANS_NONSEQ && hwrite;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_reset_end_irq: assert property (
      ev_bus_reset_end && module_enable |=> protocol_irq)
      else $error("bus reset end did not raise the protocol request");
   a_ep0_enable: assert property (
      bus_reset && module_enable |=> ep_enable[0])
      else $error("endpoint 0 not enabled after bus reset");
   a_bank_free: assert property (
      ev_tx_bank_free |=> ep_tx_bank_busy[$past(ev_endpoint)] == 1'b0)
      else $error("bank busy not cleared when bank freed");
   a_ptr_pulse_once: assert property (
      |ep_pointer_reset |=> (ep_pointer_reset & $past(ep_pointer_reset)) == 8'h00)
      else $error("pointer reset longer than one cycle");
   a_toggle_zeroed: assert property (
      |ep_pointer_reset && !ev_toggle_flip |=> (ep_data_toggle & $past(ep_pointer_reset)) == 8'h00)
      else $error("data toggle not zeroed by endpoint reset");
   a_ep_irq_cause: assert property (
      $rose(endpoint_irq) |-> $past(ev_in_ack || ev_out_data || ev_setup || ev_stall_sent)
         || $past(wr_dph) || $past(wr_dph, 2))
      else $error("endpoint request rose without a source");
   a_stall_sw_only: assert property (
      !$stable(ep_force_stall) |-> $past(wr_dph || bus_reset || !module_enable))
      else $error("force stall changed without software");
   a_enable_sw_only: assert property (
      !$stable(ep_enable) |-> $past(wr_dph || bus_reset || !module_enable))
      else $error("endpoint enable changed without cause");
endmodule : usb_ep_ctrl_properties

bind usb_device_endpoint_control usb_ep_ctrl_properties u_usb_ep_ctrl_properties (.*);

/* File: usb_link_model.sv */
`timescale 1ns/100ps
module usb_link_model (
   output logic [13:0] pulse,
   output logic [2:0] ev_endpoint,
   output logic [7:0] ev_byte_count,
   input wire logic hclk
);
   initial begin
      pulse = 14'h0;
      ev_endpoint = 3'h0;
      ev_byte_count = 8'h00;
   end
   // one-cycle event; qualifiers inverted once it is over
   task automatic fire(input int k, input logic [2:0] ep, input logic [7:0] n);
      pulse <= 14'h1 << k;
      ev_endpoint <= ep;
      ev_byte_count <= n;
      @(posedge hclk);
      pulse <= 14'h0;
      ev_endpoint <= ~ep;
      ev_byte_count <= ~n;
   endtask : fire
endmodule : usb_link_model
